// ==== src/frmv_cfg.svh ====
// Overview of operation
// RULE1 - Frame release takes no operands, undoes setup.
// RULE2 - First load stack pointer from frame base.
// RULE3 - Then pop saved frame base pointer.
// RULE4 - Eight 32-bit general registers outside 64-bit mode.
// RULE5 - Six 16-bit segment registers.
// RULE6 - 32-bit flags word and instruction pointer.
// RULE7 - Sixteen registers in 64-bit mode, widened.
// RULE8 - Flags and pointer widen in 64-bit mode.
// RULE9 - Transfer supports listed register/memory/immediate paths.
// RULE10 - No memory-to-memory or segment-to-segment move.
// RULE11 - Memory copy only via string copy.
// RULE12 - Conditioned transfer moves only when flags match.
// RULE13 - Conditioned transfer moves 16/32 bits to general.
// RULE14 - False condition leaves destination unchanged.
// RULE15 - Alias condition names decode identically.
// RULE16 - Feature query reports conditioned transfer support.
// RULE17 - Release exactly undoes frame setup.
// RULE18 - Unsigned conditions test carry, zero, parity.
// RULE19 - Signed conditions test sign, overflow, zero.
// RULE20 - Pop reads at top, then adds size.
// RULE21 - Non-moving transfer changes only instruction pointer.
`ifndef FRMV_CFG_SVH
`define FRMV_CFG_SVH
`define FRMV_GP_NUM 16
`define FRMV_GP_LEGACY 8
`define FRMV_SEG_NUM 6
`define FRMV_SP_IDX 4'h4
`define FRMV_BP_IDX 4'h5
`define FRMV_CF_BIT 0
`define FRMV_PF_BIT 2
`define FRMV_ZF_BIT 6
`define FRMV_SF_BIT 7
`define FRMV_OF_BIT 11
`define FRMV_FLAGS_RST 64'h0000000000000002
`define FRMV_CMOV_FEATURE 1'b1
`endif

// ==== src/frmv_datapath.sv ====
`include "frmv_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module frmv_datapath import frmv_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Mode and decoded instruction
  input wire logic long_mode_i,
  input wire logic req_valid_i,
  input wire frmv_req_t req_i,
  // Memory access unit and control/debug read data
  output var frmv_mem_t mem_o,
  input wire logic mem_rvalid_i,
  input wire logic [63:0] mem_rdata_i,
  input wire logic [63:0] ctl_dbg_rdata_i,
  // Status and control/debug write port
  output logic busy_o,
  output logic illegal_o,
  output logic cmov_supported_o,
  output logic [63:0] stack_top_pointer_o,
  output logic [63:0] frame_base_pointer_o,
  output logic [63:0] wide_instruction_pointer_o,
  output logic [63:0] wide_status_flags_word_o,
  output logic [63:0] ctl_dbg_wdata_o,
  output logic ctl_dbg_we_o
);
  // ----------------------------------------
  // Architectural state
  // ----------------------------------------
  logic [63:0] gp_r [`FRMV_GP_NUM]; // RULE4 RULE7
  logic [15:0] seg_r [`FRMV_SEG_NUM]; // RULE5
  logic [63:0] flags_r;
  logic [63:0] ip_r;
  frmv_state_t state_r;
  frmv_req_t cur_r;
  logic busy_r, illegal_r;
  frmv_mem_t mem_r;
  logic [63:0] cdw_r;
  logic cdwe_r;
  logic cond_ok;
  logic [63:0] opsz, mask, src_val;
  logic legal;
  logic [1:0] sz;
  // ----------------------------------------
  // Condition decode
  // ----------------------------------------
  // Aliases share one code, so they cannot diverge.
  always_comb begin // RULE15
    logic cf, zf, sf, of_, pf;
    cf = flags_r[`FRMV_CF_BIT];
    zf = flags_r[`FRMV_ZF_BIT];
    sf = flags_r[`FRMV_SF_BIT];
    of_ = flags_r[`FRMV_OF_BIT];
    pf = flags_r[`FRMV_PF_BIT];
    unique case (req_i.cond)
      4'h0: cond_ok = of_; // RULE19
      4'h1: cond_ok = !of_;
      4'h2: cond_ok = cf; // RULE18
      4'h3: cond_ok = !cf;
      4'h4: cond_ok = zf;
      4'h5: cond_ok = !zf;
      4'h6: cond_ok = cf | zf;
      4'h7: cond_ok = !(cf | zf);
      4'h8: cond_ok = sf; // RULE19
      4'h9: cond_ok = !sf;
      4'hA: cond_ok = pf; // RULE18
      4'hB: cond_ok = !pf;
      4'hC: cond_ok = sf ^ of_; // RULE19
      4'hD: cond_ok = !(sf ^ of_);
      4'hE: cond_ok = (sf ^ of_) | zf;
      4'hF: cond_ok = !((sf ^ of_) | zf);
    endcase
  end
  // ----------------------------------------
  // Operand size and legality
  // ----------------------------------------
  // Once busy, size comes from the captured request, so a decoder that
  // moves on early cannot change the pop or load width.
  assign sz = (state_r == FRMV_S_IDLE) ? req_i.size : cur_r.size;
  always_comb begin
    unique case (sz)
      2'h0: begin opsz = 64'h1; mask = 64'h00000000000000FF; end
      2'h1: begin opsz = 64'h2; mask = 64'h000000000000FFFF; end
      2'h2: begin opsz = 64'h4; mask = 64'h00000000FFFFFFFF; end
      2'h3: begin opsz = 64'h8; mask = 64'hFFFFFFFFFFFFFFFF; end
    endcase
    if (!long_mode_i && sz == 2'h3) begin // RULE6
      mask = 64'h00000000FFFFFFFF;
    end
  end
  always_comb begin
    legal = 1'b1;
    if (req_i.op == FRMV_OP_MOV) begin
      if (req_i.src_kind == FRMV_LOC_MEM && req_i.dst_kind == FRMV_LOC_MEM)
        legal = 1'b0; // RULE10 RULE11
      if (req_i.src_kind == FRMV_LOC_SEG && req_i.dst_kind == FRMV_LOC_SEG)
        legal = 1'b0; // RULE10
      if (req_i.dst_kind == FRMV_LOC_IMM)
        legal = 1'b0;
      if (req_i.src_kind == FRMV_LOC_IMM && req_i.dst_kind == FRMV_LOC_SEG)
        legal = 1'b0; // RULE9
      if ((req_i.src_kind inside {FRMV_LOC_CTL, FRMV_LOC_DBG} ||
           req_i.dst_kind inside {FRMV_LOC_CTL, FRMV_LOC_DBG}) &&
          !(req_i.src_kind == FRMV_LOC_GP || req_i.dst_kind == FRMV_LOC_GP))
        legal = 1'b0; // RULE9
    end
    if (req_i.op == FRMV_OP_CMOV) begin
      if (req_i.dst_kind != FRMV_LOC_GP ||
          !(req_i.src_kind inside {FRMV_LOC_GP, FRMV_LOC_MEM}) ||
          !(req_i.size inside {2'h1, 2'h2}))
        legal = 1'b0; // RULE13
    end
    if (!long_mode_i && (req_i.src_idx[3] || req_i.dst_idx[3]) &&
        req_i.op != FRMV_OP_RELEASE)
      legal = 1'b0; // RULE4 RULE7
    if (req_i.op == FRMV_OP_STRCPY)
      legal = (req_i.src_kind == FRMV_LOC_MEM &&
               req_i.dst_kind == FRMV_LOC_MEM); // RULE11
  end
  always_comb begin
    unique case (req_i.src_kind)
      FRMV_LOC_GP: src_val = gp_r[req_i.src_idx];
      FRMV_LOC_SEG: src_val = {48'h0, seg_r[req_i.src_idx[2:0]]};
      FRMV_LOC_IMM: src_val = req_i.imm;
      FRMV_LOC_CTL, FRMV_LOC_DBG: src_val = ctl_dbg_rdata_i;
      default: src_val = 64'h0;
    endcase
  end
  // ----------------------------------------
  // Sequencer and register writes
  // ----------------------------------------
  // One process owns all architectural state so the pop and the register
  // write can never race each other.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= FRMV_S_IDLE;
      busy_r <= 1'b0;
      illegal_r <= 1'b0;
      mem_r <= '0;
      cur_r <= '0;
      cdw_r <= 64'h0;
      cdwe_r <= 1'b0;
      flags_r <= `FRMV_FLAGS_RST;
      ip_r <= 64'h0;
      for (int i = 0; i < `FRMV_GP_NUM; i++) gp_r[i] <= 64'h0;
      for (int i = 0; i < `FRMV_SEG_NUM; i++) seg_r[i] <= 16'h0;
    end else begin
      mem_r.valid <= 1'b0;
      cdwe_r <= 1'b0;
      unique case (state_r)
        FRMV_S_IDLE: begin
          illegal_r <= 1'b0;
          if (req_valid_i) begin
            cur_r <= req_i;
            if (!legal) begin
              illegal_r <= 1'b1;
            end else begin
              ip_r <= ip_r + {60'h0, req_i.ilen}; // RULE14 RULE21
              unique case (req_i.op)
                FRMV_OP_RELEASE: begin // RULE1 RULE17
                  gp_r[`FRMV_SP_IDX] <= gp_r[`FRMV_BP_IDX]; // RULE2
                  mem_r <= '{1'b1, 1'b0, gp_r[`FRMV_BP_IDX], 64'h0}; // RULE20
                  busy_r <= 1'b1;
                  state_r <= FRMV_S_POP;
                end
                FRMV_OP_MOV, FRMV_OP_CMOV: begin
                  if (req_i.op == FRMV_OP_MOV || cond_ok) begin // RULE12
                    if (req_i.src_kind == FRMV_LOC_MEM) begin
                      mem_r <= '{1'b1, 1'b0, req_i.addr, 64'h0}; // RULE9
                      busy_r <= 1'b1;
                      state_r <= FRMV_S_MEMRD;
                    end else if (req_i.dst_kind == FRMV_LOC_MEM) begin
                      mem_r <= '{1'b1, 1'b1, req_i.addr, src_val & mask};
                    end else if (req_i.dst_kind == FRMV_LOC_SEG) begin
                      seg_r[req_i.dst_idx[2:0]] <= src_val[15:0]; // RULE5
                    end else if (req_i.dst_kind == FRMV_LOC_GP) begin
                      gp_r[req_i.dst_idx] <= src_val & mask; // RULE13
                    end else begin
                      cdw_r <= src_val & mask;
                      cdwe_r <= 1'b1;
                    end
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        FRMV_S_POP: begin
          if (mem_rvalid_i) begin
            gp_r[`FRMV_BP_IDX] <= mem_rdata_i & mask; // RULE3
            gp_r[`FRMV_SP_IDX] <= gp_r[`FRMV_SP_IDX] + opsz; // RULE20
            busy_r <= 1'b0;
            state_r <= FRMV_S_IDLE;
          end
        end
        FRMV_S_MEMRD: begin
          if (mem_rvalid_i) begin
            if (cur_r.dst_kind == FRMV_LOC_SEG)
              seg_r[cur_r.dst_idx[2:0]] <= mem_rdata_i[15:0];
            else
              gp_r[cur_r.dst_idx] <= mem_rdata_i & mask;
            busy_r <= 1'b0;
            state_r <= FRMV_S_IDLE;
          end
        end
        default: state_r <= FRMV_S_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic cmov_sup_r;
  logic [63:0] sp_o_r, bp_o_r, ip_o_r, fl_o_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmov_sup_r <= 1'b0;
      sp_o_r <= 64'h0;
      bp_o_r <= 64'h0;
      ip_o_r <= 64'h0;
      fl_o_r <= 64'h0;
    end else begin
      cmov_sup_r <= `FRMV_CMOV_FEATURE; // RULE16
      sp_o_r <= long_mode_i ? gp_r[`FRMV_SP_IDX]
                            : {32'h0, gp_r[`FRMV_SP_IDX][31:0]};
      bp_o_r <= long_mode_i ? gp_r[`FRMV_BP_IDX]
                            : {32'h0, gp_r[`FRMV_BP_IDX][31:0]};
      ip_o_r <= long_mode_i ? ip_r : {32'h0, ip_r[31:0]}; // RULE6 RULE8
      fl_o_r <= long_mode_i ? flags_r : {32'h0, flags_r[31:0]}; // RULE8
    end
  end
  assign mem_o = mem_r;
  assign busy_o = busy_r;
  assign illegal_o = illegal_r;
  assign cmov_supported_o = cmov_sup_r;
  assign stack_top_pointer_o = sp_o_r;
  assign frame_base_pointer_o = bp_o_r;
  assign wide_instruction_pointer_o = ip_o_r;
  assign wide_status_flags_word_o = fl_o_r;
  assign ctl_dbg_wdata_o = cdw_r;
  assign ctl_dbg_we_o = cdwe_r;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_release_taken;
    req_valid_i && state_r == FRMV_S_IDLE && legal &&
    req_i.op == FRMV_OP_RELEASE;
  endsequence
  sequence s_pop_answer;
    state_r == FRMV_S_POP && mem_rvalid_i;
  endsequence
  a_release_sp_load: assert property (@(posedge sys_clk_i) // RULE2
    disable iff (rst_i)
    s_release_taken |=> gp_r[`FRMV_SP_IDX] == $past(gp_r[`FRMV_BP_IDX]))
    else $error("Stack pointer not loaded from frame base.");
  a_release_pop_rd: assert property (@(posedge sys_clk_i) // RULE20
    disable iff (rst_i)
    s_release_taken |=> mem_o.valid && !mem_o.write &&
      mem_o.addr == $past(gp_r[`FRMV_BP_IDX]))
    else $error("Pop read not issued at frame base.");
  a_pop_restores_bp: assert property (@(posedge sys_clk_i) // RULE3
    disable iff (rst_i)
    s_pop_answer |=> state_r == FRMV_S_IDLE &&
      gp_r[`FRMV_BP_IDX] == ($past(mem_rdata_i) & $past(mask)))
    else $error("Frame base not restored by pop.");
  a_pop_sp_raise: assert property (@(posedge sys_clk_i) // RULE20
    disable iff (rst_i)
    s_pop_answer |=>
      gp_r[`FRMV_SP_IDX] == $past(gp_r[`FRMV_SP_IDX]) + $past(opsz))
    else $error("Stack pointer not raised by the pop size.");
  a_cmov_false_keep: assert property (@(posedge sys_clk_i) // RULE14
    disable iff (rst_i)
    req_valid_i && state_r == FRMV_S_IDLE && legal &&
    req_i.op == FRMV_OP_CMOV && !cond_ok |=>
      gp_r[$past(req_i.dst_idx)] == $past(gp_r[req_i.dst_idx]) &&
      !mem_o.valid && !busy_o)
    else $error("False condition changed state.");
  a_cmov_true_move: assert property (@(posedge sys_clk_i) // RULE12
    disable iff (rst_i)
    req_valid_i && state_r == FRMV_S_IDLE && legal &&
    req_i.op == FRMV_OP_CMOV && cond_ok &&
    req_i.src_kind == FRMV_LOC_GP |=>
      gp_r[$past(req_i.dst_idx)] == ($past(src_val) & $past(mask)))
    else $error("True condition did not move the source.");
  a_cmov_flags_keep: assert property (@(posedge sys_clk_i) // RULE21
    disable iff (rst_i)
    req_valid_i && req_i.op == FRMV_OP_CMOV |=> $stable(flags_r))
    else $error("Conditioned transfer changed flags.");
  a_ip_advance: assert property (@(posedge sys_clk_i) // RULE21
    disable iff (rst_i)
    req_valid_i && state_r == FRMV_S_IDLE && legal |=>
      ip_r == $past(ip_r) + {60'h0, $past(req_i.ilen)})
    else $error("Instruction pointer not advanced by length.");
  a_illegal_no_state: assert property (@(posedge sys_clk_i) // RULE10
    disable iff (rst_i)
    req_valid_i && state_r == FRMV_S_IDLE && !legal |=>
      illegal_o && $stable(ip_r) && !busy_o && !mem_o.valid)
    else $error("Refused request changed state.");
  a_no_mem_to_mem: assert property (@(posedge sys_clk_i) // RULE10
    disable iff (rst_i)
    req_valid_i && state_r == FRMV_S_IDLE && req_i.op == FRMV_OP_MOV &&
    req_i.src_kind == FRMV_LOC_MEM && req_i.dst_kind == FRMV_LOC_MEM |=>
      illegal_o && !mem_o.valid)
    else $error("Memory-to-memory move accepted.");
  a_below_cond: assert property (@(posedge sys_clk_i) // RULE18
    disable iff (rst_i)
    req_i.cond == 4'h6 |-> cond_ok ==
      (flags_r[`FRMV_CF_BIT] | flags_r[`FRMV_ZF_BIT]))
    else $error("Below-or-equal decode wrong.");
  a_less_eq_cond: assert property (@(posedge sys_clk_i) // RULE19
    disable iff (rst_i)
    req_i.cond == 4'hE |-> cond_ok == ((flags_r[`FRMV_SF_BIT] ^
      flags_r[`FRMV_OF_BIT]) | flags_r[`FRMV_ZF_BIT]))
    else $error("Less-or-equal decode wrong.");
  a_feature_bit: assert property (@(posedge sys_clk_i) // RULE16
    disable iff (rst_i)
    $past(!rst_i) |-> cmov_supported_o)
    else $error("Conditioned transfer support not reported.");
  a_narrow_outputs: assert property (@(posedge sys_clk_i) // RULE6
    disable iff (rst_i)
    !long_mode_i |=> wide_instruction_pointer_o[63:32] == 32'h0 &&
      wide_status_flags_word_o[63:32] == 32'h0)
    else $error("Upper half shown outside 64-bit mode.");
endmodule // frmv_datapath
`default_nettype wire

// ==== src/frmv_pkg.sv ====
package frmv_pkg;
  typedef enum logic [3:0] {
    FRMV_OP_NOP = 4'h0,
    FRMV_OP_RELEASE = 4'h1,
    FRMV_OP_MOV = 4'h2,
    FRMV_OP_CMOV = 4'h3,
    FRMV_OP_STRCPY = 4'h4
  } frmv_op_t;
  typedef enum logic [2:0] {
    FRMV_LOC_GP = 3'h0,
    FRMV_LOC_SEG = 3'h1,
    FRMV_LOC_MEM = 3'h2,
    FRMV_LOC_IMM = 3'h3,
    FRMV_LOC_CTL = 3'h4,
    FRMV_LOC_DBG = 3'h5
  } frmv_loc_t;
  typedef struct packed {
    frmv_op_t op;
    frmv_loc_t src_kind;
    frmv_loc_t dst_kind;
    logic [3:0] src_idx;
    logic [3:0] dst_idx;
    logic [3:0] cond;
    logic [1:0] size;
    logic [63:0] imm;
    logic [63:0] addr;
    logic [3:0] ilen;
  } frmv_req_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [63:0] wdata;
  } frmv_mem_t;
  typedef enum logic [1:0] {
    FRMV_S_IDLE = 2'b00,
    FRMV_S_POP = 2'b01,
    FRMV_S_MEMRD = 2'b10
  } frmv_state_t;
endpackage

// ==== verif/frmv_datapath_tb.sv ====
`include "frmv_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module frmv_datapath_tb import frmv_pkg::*;;
  typedef struct {
    logic [63:0] sp, bp, ip, a, d;
    logic ill;
    logic [1:0] k;
  } frmv_note_t;
  logic sys_clk_i, rst_i, long_mode_i, req_valid_i, mem_rvalid_i;
  logic busy_o, illegal_o, cmov_o, cwe_o, ill_seen, bsy_seen;
  logic [63:0] mem_rdata_i, ctl_dbg_rdata_i, sp_o, bp_o, ip_o, fl_o, cw_o;
  logic [63:0] gm [16];
  logic [63:0] ip_m, rd_val, obs_a, obs_d;
  logic [1:0] obs_k;
  logic [31:0] xs_st = 32'hEC38;
  frmv_req_t rq;
  frmv_mem_t mem_o;
  frmv_note_t nx;
  frmv_note_t notes [$];
  event res_ev;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  frmv_datapath DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .long_mode_i(long_mode_i),
    .req_valid_i(req_valid_i), .req_i(rq), .mem_o(mem_o),
    .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .ctl_dbg_rdata_i(ctl_dbg_rdata_i), .busy_o(busy_o),
    .illegal_o(illegal_o), .cmov_supported_o(cmov_o),
    .stack_top_pointer_o(sp_o), .frame_base_pointer_o(bp_o),
    .wide_instruction_pointer_o(ip_o), .wide_status_flags_word_o(fl_o),
    .ctl_dbg_wdata_o(cw_o), .ctl_dbg_we_o(cwe_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] xs();
    xs_st ^= xs_st << 13;
    xs_st ^= xs_st >> 17;
    xs_st ^= xs_st << 5;
    return xs_st;
  endfunction

  function automatic logic cond_true(input logic [3:0] c,
                                     input logic [63:0] f);
    logic b;
    case (c[3:1])
      3'h0: b = f[`FRMV_OF_BIT];
      3'h1: b = f[`FRMV_CF_BIT];
      3'h2: b = f[`FRMV_ZF_BIT];
      3'h3: b = f[`FRMV_CF_BIT] | f[`FRMV_ZF_BIT];
      3'h4: b = f[`FRMV_SF_BIT];
      3'h5: b = f[`FRMV_PF_BIT];
      3'h6: b = f[`FRMV_SF_BIT] ^ f[`FRMV_OF_BIT];
      default: b = (f[`FRMV_SF_BIT] ^ f[`FRMV_OF_BIT]) | f[`FRMV_ZF_BIT];
    endcase
    return b ^ c[0];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Observers and memory responder.
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  always @(posedge sys_clk_i) begin
    if (mem_o.valid === 1'b1) begin
      obs_k <= mem_o.write ? 2'd2 : 2'd1;
      obs_a <= mem_o.addr;
      obs_d <= mem_o.write ? mem_o.wdata : 64'h0;
    end
    if (cwe_o === 1'b1) begin
      obs_k <= 2'd3;
      obs_a <= 64'h0;
      obs_d <= cw_o;
    end
    if (illegal_o === 1'b1) ill_seen <= 1'b1;
  end

  // A released data bus shows the inverse so stale data never matches.
  initial begin
    forever begin
      @(posedge sys_clk_i iff (mem_o.valid === 1'b1 && !mem_o.write));
      repeat (xs() % 3 + 1) @(negedge sys_clk_i);
      mem_rvalid_i = 1'b1;
      mem_rdata_i = rd_val;
      @(negedge sys_clk_i);
      mem_rvalid_i = 1'b0;
      mem_rdata_i = ~rd_val;
    end
  end

  initial begin
    frmv_note_t n;
    forever begin
      @(res_ev);
      n = notes.pop_front();
      check(sp_o, n.sp);
      check(bp_o, n.bp);
      check(ip_o, n.ip);
      check(64'(ill_seen), 64'(n.ill));
      check(64'(bsy_seen), 64'(n.k == 2'd1));
      check(64'(obs_k), 64'(n.k));
      if (n.k != 2'd0) check(obs_a, n.a);
      if (n.k != 2'd0) check(obs_d, n.d);
      check(fl_o, `FRMV_FLAGS_RST);
      check(64'(cmov_o), 64'(`FRMV_CMOV_FEATURE));
    end
  end

  // ----------------------------------------------------------------
  // Request driver.
  // ----------------------------------------------------------------
  task automatic go(input frmv_op_t op, input frmv_loc_t sk,
                    input frmv_loc_t dk, input logic [3:0] si,
                    input logic [3:0] di);
    rq.op = op;
    rq.src_kind = sk;
    rq.dst_kind = dk;
    rq.src_idx = si;
    rq.dst_idx = di;
    rq.cond = 4'h0;
    rq.size = long_mode_i ? 2'd3 : 2'd2;
    rq.imm = long_mode_i ? {xs(), xs()} : {32'h0, xs()};
    rq.addr = {32'h0, xs() & 32'hFFFFFFF8};
    rq.ilen = 4'(xs() % 15 + 1);
    nx.ill = 1'b0;
    nx.k = 2'd0;
  endtask

  task automatic side(input logic [1:0] k, input logic [63:0] d);
    nx.k = k;
    nx.a = (k == 2'd3) ? 64'h0 : rq.addr;
    nx.d = d;
  endtask

  task automatic run();
    @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    obs_k = 2'd0;
    ill_seen = 1'b0;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    bsy_seen = busy_o;
    for (int k = 0; k < 60; k++) begin
      if (k > 2 && busy_o === 1'b0) break;
      @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    if (!nx.ill) ip_m = ip_m + 64'(rq.ilen);
    nx.sp = gm[4];
    nx.bp = gm[5];
    nx.ip = ip_m;
    notes.push_back(nx);
    ->res_ev;
  endtask

  task automatic ld(input logic [3:0] r);
    go(FRMV_OP_MOV, FRMV_LOC_IMM, FRMV_LOC_GP, 4'h0, r);
    gm[r] = rq.imm;
    run();
  endtask

  task automatic bad(input frmv_loc_t sk, input frmv_loc_t dk,
                     input logic [3:0] di);
    go(FRMV_OP_MOV, sk, dk, 4'h1, di);
    nx.ill = 1'b1;
    run();
  endtask

  initial begin
    rst_i = 1'b1;
    long_mode_i = 1'b0;
    req_valid_i = 1'b0;
    mem_rvalid_i = 1'b0;
    mem_rdata_i = 64'h0;
    ctl_dbg_rdata_i = 64'h0;
    rq = '0;
    ip_m = 64'h0;
    rd_val = 64'h0;
    foreach (gm[i]) gm[i] = 64'h0;
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    ld(4'h5);
    ld(4'h1);
    go(FRMV_OP_MOV, FRMV_LOC_GP, FRMV_LOC_GP, 4'h1, 4'h4);
    gm[4] = gm[1];
    run();
    go(FRMV_OP_MOV, FRMV_LOC_GP, FRMV_LOC_MEM, 4'h4, 4'h0);
    side(2'd2, gm[4]);
    run();
    go(FRMV_OP_MOV, FRMV_LOC_IMM, FRMV_LOC_MEM, 4'h0, 4'h0);
    side(2'd2, rq.imm);
    run();
    rd_val = {32'h0, xs()};
    go(FRMV_OP_MOV, FRMV_LOC_MEM, FRMV_LOC_GP, 4'h0, 4'h5);
    side(2'd1, 64'h0);
    gm[5] = rd_val;
    run();
    go(FRMV_OP_MOV, FRMV_LOC_GP, FRMV_LOC_CTL, 4'h1, 4'h0);
    side(2'd3, gm[1]);
    run();
    ctl_dbg_rdata_i = {32'h0, xs()};
    go(FRMV_OP_MOV, FRMV_LOC_DBG, FRMV_LOC_GP, 4'h0, 4'h4);
    gm[4] = ctl_dbg_rdata_i;
    run();
    go(FRMV_OP_MOV, FRMV_LOC_GP, FRMV_LOC_SEG, 4'h1, 4'h2);
    run();
    go(FRMV_OP_MOV, FRMV_LOC_SEG, FRMV_LOC_GP, 4'h2, 4'h4);
    gm[4] = {48'h0, gm[1][15:0]};
    run();
    $display("test moves done");
    bad(FRMV_LOC_MEM, FRMV_LOC_MEM, 4'h0);
    bad(FRMV_LOC_SEG, FRMV_LOC_SEG, 4'h2);
    bad(FRMV_LOC_IMM, FRMV_LOC_SEG, 4'h2);
    bad(FRMV_LOC_IMM, FRMV_LOC_GP, 4'h8);
    go(FRMV_OP_STRCPY, FRMV_LOC_MEM, FRMV_LOC_MEM, 4'h0, 4'h0);
    run();
    $display("test refusals done");
    for (int c = 0; c < 16; c++) begin
      ld(4'h1);
      go(FRMV_OP_CMOV, FRMV_LOC_GP, FRMV_LOC_GP, 4'h1, 4'h4);
      rq.cond = 4'(c);
      if (cond_true(4'(c), `FRMV_FLAGS_RST)) gm[4] = gm[1];
      run();
    end
    rd_val = {32'h0, xs()};
    go(FRMV_OP_CMOV, FRMV_LOC_MEM, FRMV_LOC_GP, 4'h0, 4'h5);
    rq.cond = 4'h1;
    side(2'd1, 64'h0);
    gm[5] = rd_val;
    run();
    $display("test conditioned moves done");
    for (int m = 0; m < 2; m++) begin
      long_mode_i = m[0];
      ld(4'h4);
      ld(4'h5);
      rd_val = m[0] ? {xs(), xs()} : {32'h0, xs()};
      go(FRMV_OP_RELEASE, FRMV_LOC_GP, FRMV_LOC_GP, 4'h0, 4'h0);
      side(2'd1, 64'h0);
      nx.a = gm[5];
      gm[4] = gm[5] + (64'h1 << rq.size);
      gm[5] = rd_val;
      run();
    end
    ld(4'hC);
    go(FRMV_OP_MOV, FRMV_LOC_GP, FRMV_LOC_GP, 4'hC, 4'h4);
    gm[4] = gm[12];
    run();
    $display("test release and wide mode done");
    give_verdict();
  end
endmodule // frmv_datapath_tb
`default_nettype wire
